/* pmx_defs.vh */
/*
 Constants for the port 2 / port 3 pin function multiplexer.
 Assumes inclusion by pmx_port23_mux.v only; definitions, no logic.
*/
// Contract
// - Port2 line7 select: 0 port, 1 serial1 transmit, 2 converter1 sense in.
// - Port2 line6 select: 0 port, 1 converter0 sense input, others reserved.
// - Port2 line5 select: 0 port, 1 converter0 reference output.
// - Port2 line4 select: 0 port, 1 converter0 sensor A output.
// - Port3 line3 select: 0 port, 1 I2C1 clock, 2 I2C0 clock, 3 timer6 A.
// - Port3 line2 select: 0 port, 1 I2C0 data, 2 converter1 sensor B, 3 timer5 B.
// - Port3 line1 select: 0 port, 1 I2C0 clock, 2 converter1 sensor A, 3 timer5 A.
// - Port3 line0 select: 0 port, 1 serial1 receive, 2 converter1 reference.
// - Port3 line7: 0 port plus ext clock6, 1 inverted timer3, 2 slow osc, 3 timer4.
// - Port3 line6: 0 port plus ext clock5, 1 timer3, 2 converter clock.
// - Port3 line5 select: 0 port, 1 clock generator out1, 2 bus fault request.
// - Port3 line4 select: 0 port, 1 I2C1 data, 2 I2C0 data, 3 timer6 B.
`ifndef PMX_DEFS_VH
`define PMX_DEFS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PMX_ADDR_W 16
`define PMX_P2H_OFS 16'h52a5
`define PMX_P3L_OFS 16'h52a6
`define PMX_P3H_OFS 16'h52a7
`define PMX_RESET_VAL 8'h00

// ----------------------------------------
// Field positions in the 24-bit select vector
// ----------------------------------------
`define PMX_P24 4'h0
`define PMX_P25 4'h1
`define PMX_P26 4'h2
`define PMX_P27 4'h3
`define PMX_P30 4'h4
`define PMX_P31 4'h5
`define PMX_P32 4'h6
`define PMX_P33 4'h7
`define PMX_P34 4'h8
`define PMX_P35 4'h9
`define PMX_P36 4'ha
`define PMX_P37 4'hb

// ----------------------------------------
// Select codes
// ----------------------------------------
`define PMX_SEL_PORT 2'h0
`define PMX_SEL_ONE 2'h1
`define PMX_SEL_TWO 2'h2
`define PMX_SEL_THREE 2'h3

`endif

/* pmx_port23_mux.v */
/*
 Pin function multiplexer for port 2 lines 4-7 and port 3 lines 0-7:
 three select registers on a plain register port, pad output/enable
 steering and pad input distribution to peripherals.
 Assumes pads resolve o_pad_out/o_pad_oe into wires and return the
 level on i_pad_in asynchronously; peripherals share i_clk.
*/
// Implementation choice: the plain strobed port.
`include "pmx_defs.vh"

module pmx_port23_mux (
  input wire i_clk,
  input wire i_resetn,
  input wire [15:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire [11:0] i_gpio_out,
  input wire [11:0] i_gpio_oe,
  output reg [11:0] o_gpio_in,
  input wire [11:0] i_pad_in,
  output reg [11:0] o_pad_out,
  output reg [11:0] o_pad_oe,
  input wire i_serial1_tx_out,
  input wire i_conv0_reference_out,
  input wire i_conv1_reference_out,
  input wire i_conv0_sensor_a_out,
  input wire i_conv1_sensor_a_out,
  input wire i_conv1_sensor_b_out,
  input wire i_i2c_ch0_clock_oe,
  input wire i_i2c_ch1_clock_oe,
  input wire i_i2c_ch0_data_oe,
  input wire i_i2c_ch1_data_oe,
  input wire i_timer5_out_a,
  input wire i_timer5_out_a_oe,
  input wire i_timer5_out_b,
  input wire i_timer5_out_b_oe,
  input wire i_timer6_out_a,
  input wire i_timer6_out_a_oe,
  input wire i_timer6_out_b,
  input wire i_timer6_out_b_oe,
  input wire i_timer_three_out,
  input wire i_timer_three_out_inverted,
  input wire i_timer_four_out,
  input wire i_low_speed_osc_clock_out,
  input wire i_converter_clock_out,
  input wire i_clock_gen_out_one,
  output reg o_serial1_rx_in,
  output reg o_conv0_sense_in,
  output reg o_conv1_sense_in,
  output reg o_i2c_ch0_clock,
  output reg o_i2c_ch1_clock,
  output reg o_i2c_ch0_data,
  output reg o_i2c_ch1_data,
  output reg o_timer5_capture_a,
  output reg o_timer5_capture_b,
  output reg o_timer6_capture_a,
  output reg o_timer6_capture_b,
  output reg o_bus_fault_request_n,
  output reg o_ext_timer_clock_five,
  output reg o_ext_timer_clock_six
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [7:0] port2_high_function_select;
  reg [7:0] port3_low_function_select;
  reg [7:0] port3_high_function_select;
  reg [11:0] pad_meta;
  reg [11:0] pad_sync;
  wire [23:0] sel_all;
  reg [11:0] next_pad_out;
  reg [11:0] next_pad_oe;
  reg [11:0] next_gpio_in;
  reg next_rx;
  reg next_sense0;
  reg next_sense1;
  reg next_i2c_ch0_clock;
  reg next_i2c_ch1_clock;
  reg next_i2c_ch0_data;
  reg next_i2c_ch1_data;
  reg next_cap5a;
  reg next_cap5b;
  reg next_cap6a;
  reg next_cap6b;
  reg next_bfr_n;
  reg next_ext_timer_clock_five;
  reg next_ext_timer_clock_six;
  reg [7:0] next_rdata;

  // Field of one pin out of the joined select vector
  function [1:0] pmx_sel;
    input [23:0] s;
    input [3:0] pin;
    begin
      pmx_sel = s[{pin, 1'b0} +: 2];
    end
  endfunction

  assign sel_all = {port3_high_function_select,
                    port3_low_function_select,
                    port2_high_function_select};

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // Plain writes, no side effects; zero reset puts every pin on the port
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      port2_high_function_select <= `PMX_RESET_VAL;
      port3_low_function_select <= `PMX_RESET_VAL;
      port3_high_function_select <= `PMX_RESET_VAL;
    end
    else if (i_wr)
    begin
      if (i_addr == `PMX_P2H_OFS)
        port2_high_function_select <= i_wdata;
      else if (i_addr == `PMX_P3L_OFS)
        port3_low_function_select <= i_wdata;
      else if (i_addr == `PMX_P3H_OFS)
        port3_high_function_select <= i_wdata;
    end
  end

  // Read mux; unmapped addresses answer zero
  always @*
  begin
    next_rdata = 8'h00;
    if (i_addr == `PMX_P2H_OFS)
      next_rdata = port2_high_function_select;
    else if (i_addr == `PMX_P3L_OFS)
      next_rdata = port3_low_function_select;
    else if (i_addr == `PMX_P3H_OFS)
      next_rdata = port3_high_function_select;
  end

  // ----------------------------------------
  // Pad input synchroniser
  // ----------------------------------------
  // Pads are asynchronous; only pad_sync feeds the routing logic
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pad_meta <= 12'h000;
      pad_sync <= 12'h000;
    end
    else
    begin
      pad_meta <= i_pad_in;
      pad_sync <= pad_meta;
    end
  end

  // ----------------------------------------
  // Routing
  // ----------------------------------------
  // Reserved codes leave the pad undriven and its input unused.
  // I2C lines are open drain: drive low while the peripheral pulls.
  // Idle I2C and bus-fault inputs read high, as a pulled-up wire would.
  always @*
  begin
    next_pad_out = 12'h000;
    next_pad_oe = 12'h000;
    next_gpio_in = 12'h000;
    next_rx = 1'b0;
    next_sense0 = 1'b0;
    next_sense1 = 1'b0;
    next_i2c_ch0_clock = 1'b1;
    next_i2c_ch1_clock = 1'b1;
    next_i2c_ch0_data = 1'b1;
    next_i2c_ch1_data = 1'b1;
    next_cap5a = 1'b0;
    next_cap5b = 1'b0;
    next_cap6a = 1'b0;
    next_cap6b = 1'b0;
    next_bfr_n = 1'b1;
    next_ext_timer_clock_five = 1'b0;
    next_ext_timer_clock_six = 1'b0;
    // Port-selected pins pass the port logic straight through
    if (pmx_sel(sel_all, `PMX_P24) == `PMX_SEL_PORT)
      next_gpio_in[0] = pad_sync[0];
    if (pmx_sel(sel_all, `PMX_P25) == `PMX_SEL_PORT)
      next_gpio_in[1] = pad_sync[1];
    if (pmx_sel(sel_all, `PMX_P26) == `PMX_SEL_PORT)
      next_gpio_in[2] = pad_sync[2];
    if (pmx_sel(sel_all, `PMX_P27) == `PMX_SEL_PORT)
      next_gpio_in[3] = pad_sync[3];
    if (pmx_sel(sel_all, `PMX_P30) == `PMX_SEL_PORT)
      next_gpio_in[4] = pad_sync[4];
    if (pmx_sel(sel_all, `PMX_P31) == `PMX_SEL_PORT)
      next_gpio_in[5] = pad_sync[5];
    if (pmx_sel(sel_all, `PMX_P32) == `PMX_SEL_PORT)
      next_gpio_in[6] = pad_sync[6];
    if (pmx_sel(sel_all, `PMX_P33) == `PMX_SEL_PORT)
      next_gpio_in[7] = pad_sync[7];
    if (pmx_sel(sel_all, `PMX_P34) == `PMX_SEL_PORT)
      next_gpio_in[8] = pad_sync[8];
    if (pmx_sel(sel_all, `PMX_P35) == `PMX_SEL_PORT)
      next_gpio_in[9] = pad_sync[9];
    if (pmx_sel(sel_all, `PMX_P36) == `PMX_SEL_PORT)
      next_gpio_in[10] = pad_sync[10];
    if (pmx_sel(sel_all, `PMX_P37) == `PMX_SEL_PORT)
      next_gpio_in[11] = pad_sync[11];
    next_pad_out = i_gpio_out & {12{1'b1}};
    // Port 2 line 4
    case (pmx_sel(sel_all, `PMX_P24))
      `PMX_SEL_PORT: next_pad_oe[0] = i_gpio_oe[0];
      `PMX_SEL_ONE:
      begin
        next_pad_out[0] = i_conv0_sensor_a_out;
        next_pad_oe[0] = 1'b1;
      end
      default: next_pad_out[0] = 1'b0;
    endcase
    // Port 2 line 5
    case (pmx_sel(sel_all, `PMX_P25))
      `PMX_SEL_PORT: next_pad_oe[1] = i_gpio_oe[1];
      `PMX_SEL_ONE:
      begin
        next_pad_out[1] = i_conv0_reference_out;
        next_pad_oe[1] = 1'b1;
      end
      default: next_pad_out[1] = 1'b0;
    endcase
    // Port 2 line 6
    case (pmx_sel(sel_all, `PMX_P26))
      `PMX_SEL_PORT: next_pad_oe[2] = i_gpio_oe[2];
      `PMX_SEL_ONE: next_sense0 = pad_sync[2];
      default: next_pad_out[2] = 1'b0;
    endcase
    // Port 2 line 7
    case (pmx_sel(sel_all, `PMX_P27))
      `PMX_SEL_PORT: next_pad_oe[3] = i_gpio_oe[3];
      `PMX_SEL_ONE:
      begin
        next_pad_out[3] = i_serial1_tx_out;
        next_pad_oe[3] = 1'b1;
      end
      `PMX_SEL_TWO: next_sense1 = pad_sync[3];
      default: next_pad_out[3] = 1'b0;
    endcase
    // Port 3 line 0
    case (pmx_sel(sel_all, `PMX_P30))
      `PMX_SEL_PORT: next_pad_oe[4] = i_gpio_oe[4];
      `PMX_SEL_ONE: next_rx = pad_sync[4];
      `PMX_SEL_TWO:
      begin
        next_pad_out[4] = i_conv1_reference_out;
        next_pad_oe[4] = 1'b1;
      end
      default: next_pad_out[4] = 1'b0;
    endcase
    // Port 3 line 1; timer 5 exists only on some variants
    case (pmx_sel(sel_all, `PMX_P31))
      `PMX_SEL_PORT: next_pad_oe[5] = i_gpio_oe[5];
      `PMX_SEL_ONE:
      begin
        next_pad_out[5] = 1'b0;
        next_pad_oe[5] = i_i2c_ch0_clock_oe;
        next_i2c_ch0_clock = next_i2c_ch0_clock & pad_sync[5];
      end
      `PMX_SEL_TWO:
      begin
        next_pad_out[5] = i_conv1_sensor_a_out;
        next_pad_oe[5] = 1'b1;
      end
      default:
      begin
        next_pad_out[5] = i_timer5_out_a;
        next_pad_oe[5] = i_timer5_out_a_oe;
        next_cap5a = pad_sync[5];
      end
    endcase
    // Port 3 line 2
    case (pmx_sel(sel_all, `PMX_P32))
      `PMX_SEL_PORT: next_pad_oe[6] = i_gpio_oe[6];
      `PMX_SEL_ONE:
      begin
        next_pad_out[6] = 1'b0;
        next_pad_oe[6] = i_i2c_ch0_data_oe;
        next_i2c_ch0_data = next_i2c_ch0_data & pad_sync[6];
      end
      `PMX_SEL_TWO:
      begin
        next_pad_out[6] = i_conv1_sensor_b_out;
        next_pad_oe[6] = 1'b1;
      end
      default:
      begin
        next_pad_out[6] = i_timer5_out_b;
        next_pad_oe[6] = i_timer5_out_b_oe;
        next_cap5b = pad_sync[6];
      end
    endcase
    // Port 3 line 3; I2C0 clock may sit here or on line 1
    case (pmx_sel(sel_all, `PMX_P33))
      `PMX_SEL_PORT: next_pad_oe[7] = i_gpio_oe[7];
      `PMX_SEL_ONE:
      begin
        next_pad_out[7] = 1'b0;
        next_pad_oe[7] = i_i2c_ch1_clock_oe;
        next_i2c_ch1_clock = pad_sync[7];
      end
      `PMX_SEL_TWO:
      begin
        next_pad_out[7] = 1'b0;
        next_pad_oe[7] = i_i2c_ch0_clock_oe;
        next_i2c_ch0_clock = next_i2c_ch0_clock & pad_sync[7];
      end
      default:
      begin
        next_pad_out[7] = i_timer6_out_a;
        next_pad_oe[7] = i_timer6_out_a_oe;
        next_cap6a = pad_sync[7];
      end
    endcase
    // Port 3 line 4; I2C0 data may sit here or on line 2
    case (pmx_sel(sel_all, `PMX_P34))
      `PMX_SEL_PORT: next_pad_oe[8] = i_gpio_oe[8];
      `PMX_SEL_ONE:
      begin
        next_pad_out[8] = 1'b0;
        next_pad_oe[8] = i_i2c_ch1_data_oe;
        next_i2c_ch1_data = pad_sync[8];
      end
      `PMX_SEL_TWO:
      begin
        next_pad_out[8] = 1'b0;
        next_pad_oe[8] = i_i2c_ch0_data_oe;
        next_i2c_ch0_data = next_i2c_ch0_data & pad_sync[8];
      end
      default:
      begin
        next_pad_out[8] = i_timer6_out_b;
        next_pad_oe[8] = i_timer6_out_b_oe;
        next_cap6b = pad_sync[8];
      end
    endcase
    // Port 3 line 5
    case (pmx_sel(sel_all, `PMX_P35))
      `PMX_SEL_PORT: next_pad_oe[9] = i_gpio_oe[9];
      `PMX_SEL_ONE:
      begin
        next_pad_out[9] = i_clock_gen_out_one;
        next_pad_oe[9] = 1'b1;
      end
      `PMX_SEL_TWO: next_bfr_n = pad_sync[9];
      default: next_pad_out[9] = 1'b0;
    endcase
    // Port 3 line 6; clock input shares the port setting
    case (pmx_sel(sel_all, `PMX_P36))
      `PMX_SEL_PORT:
      begin
        next_pad_oe[10] = i_gpio_oe[10];
        next_ext_timer_clock_five = pad_sync[10];
      end
      `PMX_SEL_ONE:
      begin
        next_pad_out[10] = i_timer_three_out;
        next_pad_oe[10] = 1'b1;
      end
      `PMX_SEL_TWO:
      begin
        next_pad_out[10] = i_converter_clock_out;
        next_pad_oe[10] = 1'b1;
      end
      default: next_pad_out[10] = 1'b0;
    endcase
    // Port 3 line 7
    case (pmx_sel(sel_all, `PMX_P37))
      `PMX_SEL_PORT:
      begin
        next_pad_oe[11] = i_gpio_oe[11];
        next_ext_timer_clock_six = pad_sync[11];
      end
      `PMX_SEL_ONE:
      begin
        next_pad_out[11] = i_timer_three_out_inverted;
        next_pad_oe[11] = 1'b1;
      end
      `PMX_SEL_TWO:
      begin
        next_pad_out[11] = i_low_speed_osc_clock_out;
        next_pad_oe[11] = 1'b1;
      end
      default:
      begin
        next_pad_out[11] = i_timer_four_out;
        next_pad_oe[11] = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // Every output is a flop: one cycle from select or peripheral change
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rdata <= 8'h00;
      o_gpio_in <= 12'h000;
      o_pad_out <= 12'h000;
      o_pad_oe <= 12'h000;
      o_serial1_rx_in <= 1'b0;
      o_conv0_sense_in <= 1'b0;
      o_conv1_sense_in <= 1'b0;
      o_i2c_ch0_clock <= 1'b1;
      o_i2c_ch1_clock <= 1'b1;
      o_i2c_ch0_data <= 1'b1;
      o_i2c_ch1_data <= 1'b1;
      o_timer5_capture_a <= 1'b0;
      o_timer5_capture_b <= 1'b0;
      o_timer6_capture_a <= 1'b0;
      o_timer6_capture_b <= 1'b0;
      o_bus_fault_request_n <= 1'b1;
      o_ext_timer_clock_five <= 1'b0;
      o_ext_timer_clock_six <= 1'b0;
    end
    else
    begin
      if (i_rd)
        o_rdata <= next_rdata;
      else
        o_rdata <= 8'h00; // Data stand only the cycle after the read
      o_gpio_in <= next_gpio_in;
      o_pad_out <= next_pad_out;
      o_pad_oe <= next_pad_oe;
      o_serial1_rx_in <= next_rx;
      o_conv0_sense_in <= next_sense0;
      o_conv1_sense_in <= next_sense1;
      o_i2c_ch0_clock <= next_i2c_ch0_clock;
      o_i2c_ch1_clock <= next_i2c_ch1_clock;
      o_i2c_ch0_data <= next_i2c_ch0_data;
      o_i2c_ch1_data <= next_i2c_ch1_data;
      o_timer5_capture_a <= next_cap5a;
      o_timer5_capture_b <= next_cap5b;
      o_timer6_capture_a <= next_cap6a;
      o_timer6_capture_b <= next_cap6b;
      o_bus_fault_request_n <= next_bfr_n;
      o_ext_timer_clock_five <= next_ext_timer_clock_five;
      o_ext_timer_clock_six <= next_ext_timer_clock_six;
    end
  end

endmodule // pmx_port23_mux

/* pmx_port23_mux_chk.sv */
/* Checker for the port 2/3 function mux: register port and routing.
 Assumes one clock with async active-low reset; bound to the mux ports. */
module pmx_port23_mux_chk (
  input wire i_clk,
  input wire i_resetn,
  input wire [15:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire [11:0] i_gpio_oe,
  input wire [11:0] i_pad_in,
  input wire [11:0] o_gpio_in,
  input wire [11:0] o_pad_out,
  input wire [11:0] o_pad_oe,
  input wire i_serial1_tx_out,
  input wire i_timer_four_out,
  input wire i_i2c_ch1_clock_oe,
  input wire o_serial1_rx_in,
  input wire o_bus_fault_request_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] p2h, p3l, p3h;
  logic [7:0] sel_rd;
  // --------
  // Shadow select registers
  // --------
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      p2h <= 8'h00;
      p3l <= 8'h00;
      p3h <= 8'h00;
    end
    else if (i_wr)
    begin
      if (i_addr == 16'h52a5) p2h <= i_wdata;
      if (i_addr == 16'h52a6) p3l <= i_wdata;
      if (i_addr == 16'h52a7) p3h <= i_wdata;
    end
  end
  assign sel_rd = (i_addr == 16'h52a5) ? p2h : (i_addr == 16'h52a6) ? p3l : p3h;
  // --------
  // Properties
  // --------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence rd_map;
    i_rd && i_addr >= 16'h52a5 && i_addr <= 16'h52a7;
  endsequence
  // Inputs pass two sync stages, so the route must hold four edges
  sequence rx_held;
    (p3l[1:0] == 2'h1) [*4];
  endsequence
  sequence fault_held;
    (p3h[3:2] == 2'h2) [*4];
  endsequence
  rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not cleared");
  read_back_a: assert property (rd_map |=> o_rdata == $past(sel_rd))
    else $error("read data differs from last write");
  tx_route_a: assert property (p2h[7:6] == 2'h1 |=> o_pad_oe[3]
    && o_pad_out[3] == $past(i_serial1_tx_out)) else $error("serial transmit not on pad");
  sense_pad_a: assert property (p2h[5:4] != 2'h0 |=> !o_pad_oe[2])
    else $error("sense input pin driven");
  port_pass_a: assert property (p2h[1:0] == 2'h0 |=> o_pad_oe[0] == $past(i_gpio_oe[0]))
    else $error("port enable not passed");
  scl_pull_a: assert property (p3l[7:6] == 2'h1 && i_i2c_ch1_clock_oe
    |=> o_pad_oe[7] && !o_pad_out[7]) else $error("clock line not pulled low");
  rx_route_a: assert property (rx_held |-> o_serial1_rx_in == $past(i_pad_in[4], 3))
    else $error("receive input not routed");
  port_gate_a: assert property ((p3l[1:0] != 2'h0) [*2] |-> !o_gpio_in[4])
    else $error("port input seen on peripheral pin");
  timer_route_a: assert property (p3h[7:6] == 2'h3 |=> o_pad_oe[11]
    && o_pad_out[11] == $past(i_timer_four_out)) else $error("timer output not on pad");
  fault_route_a: assert property (fault_held
    |-> o_bus_fault_request_n == $past(i_pad_in[9], 3)) else $error("fault request not routed");
endmodule // pmx_port23_mux_chk

bind pmx_port23_mux pmx_port23_mux_chk u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_gpio_oe(i_gpio_oe), .i_pad_in(i_pad_in), .o_gpio_in(o_gpio_in), .o_pad_out(o_pad_out),
  .o_pad_oe(o_pad_oe), .i_serial1_tx_out(i_serial1_tx_out), .i_timer_four_out(i_timer_four_out),
  .i_i2c_ch1_clock_oe(i_i2c_ch1_clock_oe), .o_serial1_rx_in(o_serial1_rx_in),
  .o_bus_fault_request_n(o_bus_fault_request_n));

/* pmx_periph_model.sv */
/* Peripherals and package pins around the mux.
 Assumes the bench supplies peripheral levels and outside pin drive. */
module pmx_periph_model (
  input wire [23:0] i_level,
  input wire [11:0] i_ext,
  input wire [11:0] i_pad_out,
  input wire [11:0] i_pad_oe,
  output logic [23:0] o_periph,
  output logic [11:0] o_pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Undriven pins follow outside drive, which changes every step
  assign o_pad_in = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext);
  assign o_periph = i_level;
endmodule // pmx_periph_model

/* pmx_port23_mux_bench.sv */
/* Self-checking bench for the port 2/3 function mux.
 Assumes the mux, its checker and the peripheral model are compiled. */
module pmx_port23_mux_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // Per pin and code: kind (1 drive, 2 pull low, 3 timer) and source bit
  localparam logic [0:35][7:0] route_tab = {8'h23, 8'h00, 8'h00, 8'h21, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h22, 8'h00, 8'h46, 8'h24, 8'h6a,
    8'h48, 8'h25, 8'h6c, 8'h47, 8'h46, 8'h6e, 8'h49, 8'h48, 8'h70, 8'h37, 8'h00, 8'h00,
    8'h32, 8'h36, 8'h00, 8'h33, 8'h35, 8'h34};
  logic clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [11:0] gpio_out = 12'h000, gpio_oe = 12'h000, ext = 12'h000;
  logic [23:0] level = 24'h000000;
  logic [31:0] seed = 32'hd30b;
  logic [7:0] mreg [0:2] = '{8'h00, 8'h00, 8'h00};
  wire [7:0] rdata;
  wire [11:0] gpio_in, pad_in, pad_out, pad_oe;
  wire [23:0] per;
  wire [13:0] ins;
  // Highest defined code per pin; anything above it is reserved
  localparam logic [0:11][1:0] code_max = {2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3,
    2'h3, 2'h2, 2'h2, 2'h3};
  int mismatches = 0, tests_run = 0;
  pmx_periph_model u_pmx_periph_model (.i_level(level), .i_ext(ext), .i_pad_out(pad_out),
    .i_pad_oe(pad_oe), .o_periph(per), .o_pad_in(pad_in));
  pmx_port23_mux u_pmx_port23_mux (.i_clk(clk), .i_resetn(resetn), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_gpio_out(gpio_out),
    .i_gpio_oe(gpio_oe), .o_gpio_in(gpio_in), .i_pad_in(pad_in), .o_pad_out(pad_out),
    .o_pad_oe(pad_oe), .i_serial1_tx_out(per[0]), .i_conv0_reference_out(per[1]),
    .i_conv1_reference_out(per[2]), .i_conv0_sensor_a_out(per[3]),
    .i_conv1_sensor_a_out(per[4]), .i_conv1_sensor_b_out(per[5]),
    .i_i2c_ch0_clock_oe(per[6]), .i_i2c_ch1_clock_oe(per[7]), .i_i2c_ch0_data_oe(per[8]),
    .i_i2c_ch1_data_oe(per[9]), .i_timer5_out_a(per[10]), .i_timer5_out_a_oe(per[11]),
    .i_timer5_out_b(per[12]), .i_timer5_out_b_oe(per[13]), .i_timer6_out_a(per[14]),
    .i_timer6_out_a_oe(per[15]), .i_timer6_out_b(per[16]), .i_timer6_out_b_oe(per[17]),
    .i_timer_three_out(per[18]), .i_timer_three_out_inverted(per[19]),
    .i_timer_four_out(per[20]), .i_low_speed_osc_clock_out(per[21]),
    .i_converter_clock_out(per[22]), .i_clock_gen_out_one(per[23]),
    .o_serial1_rx_in(ins[0]), .o_conv0_sense_in(ins[1]), .o_conv1_sense_in(ins[2]),
    .o_i2c_ch0_clock(ins[3]), .o_i2c_ch1_clock(ins[4]), .o_i2c_ch0_data(ins[5]),
    .o_i2c_ch1_data(ins[6]), .o_timer5_capture_a(ins[10]), .o_timer5_capture_b(ins[11]),
    .o_timer6_capture_a(ins[12]), .o_timer6_capture_b(ins[13]),
    .o_bus_fault_request_n(ins[7]),
    .o_ext_timer_clock_five(ins[8]), .o_ext_timer_clock_six(ins[9]));
  // --------
  // Reference model and helpers
  // --------
  function automatic [31:0] lfsr(input logic [31:0] s);
    for (int n = 0; n < 16; n++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  // Software clears a reserved field before it writes the register
  function automatic [7:0] legal(int i, logic [7:0] v);
    for (int j = 0; j < 4; j++)
      if (v[2 * j +: 2] > code_max[i * 4 + j]) v[2 * j +: 2] = 2'h0;
    return v;
  endfunction
  function automatic [1:0] code(int k);
    logic [7:0] r;
    r = mreg[k / 4];
    return r[2 * (k % 4) +: 2];
  endfunction
  // Expected {enable, value} of pin k
  function automatic [1:0] epad(int k);
    logic [7:0] e;
    if (code(k) == 2'h0) return {gpio_oe[k], gpio_out[k]};
    e = route_tab[k * 3 + code(k) - 1];
    case (e[6:5])
      2'h1: return {1'b1, level[e[4:0]]};
      2'h2: return {level[e[4:0]], 1'b0};
      2'h3: return {level[e[4:0] + 1], level[e[4:0]]};
      default: return 2'h0;
    endcase
  endfunction
  // Level a routed input sees, or its idle value
  function automatic rt(int k, logic [1:0] c, logic idle);
    logic [1:0] e;
    e = epad(k);
    return (code(k) == c) ? (e[1] ? e[0] : ext[k]) : idle;
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    for (int i = 0; i < 3; i++) if (a == 16'h52a5 + i) mreg[i] = d;
  endtask
  // Reads the map plus both neighbours, which must read as zero
  task automatic rd_all;
    logic [7:0] d;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      addr <= 16'(16'h52a4 + i);
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
      check(d, (i == 0 || i == 4) ? 8'h00 : mreg[i - 1]);
    end
  endtask
  task automatic chk_route;
    logic [1:0] e;
    repeat (6) @(posedge clk);
    @(negedge clk);
    for (int k = 0; k < 12; k++)
    begin
      e = epad(k);
      check({pad_oe[k], pad_oe[k] & pad_out[k]}, {e[1], e[1] & e[0]});
      check(gpio_in[k], rt(k, 2'h0, 1'b0));
    end
    check(ins[0], rt(4, 2'h1, 1'b0));
    check(ins[1], rt(2, 2'h1, 1'b0));
    check(ins[2], rt(3, 2'h2, 1'b0));
    check(ins[3], rt(5, 2'h1, 1'b1) & rt(7, 2'h2, 1'b1));
    check(ins[4], rt(7, 2'h1, 1'b1));
    check(ins[5], rt(6, 2'h1, 1'b1) & rt(8, 2'h2, 1'b1));
    check(ins[6], rt(8, 2'h1, 1'b1));
    check(ins[7], rt(9, 2'h2, 1'b1));
    check(ins[8], rt(10, 2'h0, 1'b0));
    check(ins[9], rt(11, 2'h0, 1'b0));
    check(ins[10], rt(5, 2'h3, 1'b0));
    check(ins[11], rt(6, 2'h3, 1'b0));
    check(ins[12], rt(7, 2'h3, 1'b0));
    check(ins[13], rt(8, 2'h3, 1'b0));
  endtask
  task automatic stop_test;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // --------
  // Clock, watchdog and sequence
  // --------
  initial
  begin
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd_all();
    // Random legal codes with random pin traffic
    repeat (40)
    begin
      for (int i = 0; i < 3; i++)
      begin
        seed = lfsr(seed);
        wr_reg(16'(16'h52a5 + i), legal(i, seed[7:0]));
      end
      wr_reg(16'h52a8, seed[15:8]);
      seed = lfsr(seed);
      gpio_out <= seed[11:0];
      gpio_oe <= seed[23:12];
      seed = lfsr(seed);
      ext <= seed[11:0];
      level <= seed[31:8];
      chk_route();
      rd_all();
    end
    // Reset in mid-run returns every pin to the port
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    mreg = '{8'h00, 8'h00, 8'h00};
    chk_route();
    rd_all();
    stop_test();
  end
endmodule // pmx_port23_mux_bench
